// ==== src/dos_defines.vh ====
// constants for the diagnostic output selector
`ifndef DOS_DEFINES_VH
`define DOS_DEFINES_VH
`define DOS_TYPE_ANALOG 2'h2
`define DOS_TYPE_DIGITAL 2'h1
`define DOS_SEL_RESET 8'h00
`define DOS_TYPE_RESET 2'h0
`define DOS_EN_RESET 1'h0
`define DOS_SYNC_RESET 1'h0
`define DOS_OUT_RESET 1'h0
`define DOS_ACH_RESET 3'h0
`define DOS_GRP_MSB 6
`define DOS_GRP_LSB 4
`define DOS_CH_MSB 3
`define DOS_CH_LSB 0
`define DOS_GRP_MON 3'h0
`define DOS_GRP_CLK 3'h1
`define DOS_GRP_ILIM 3'h2
`define DOS_MON_MASK 16'h9F82
`define DOS_CLK_MASK 16'h00BF
`define DOS_ILIM_MASK 16'h01FE
`define DOS_ACH_FIRST 8'h01
`define DOS_ACH_LAST 8'h06
`define DOS_SYSCLK_KHZ 8000
`define DOS_SYSCLK_TOL_PCT 5
`endif

// ==== src/dos_observe_mux.v ====
// diagnostic output selector: analog and digital observation mux
//
// Operation
// - output enable cleared leaves the observe pin undriven, any selection.
// - type 10b selects analog; digital buffer stays off, analog driven.
// - type 01b selects digital; analog buffer stays off, digital driven.
// - io supply overvoltage removes supply from both buffers; pin undriven.
// - analog codes 01h to 06h route the six listed internal nodes.
// - analog code zero or 07h to FFh selects nothing, driver off.
// - group 000b routes regulator, buck, boost and io comparators.
// - group 001b routes the clock sources; groups 011b to 111b output 0.
// - system clock on group 001b channel 0001b is nominally 8 MHz.
// - group 010b routes first and second buck limits and protections.
`timescale 1ns/100ps
`include "dos_defines.vh"
module dos_observe_mux (
  input wire CORE_CLK,
  input wire RST,
  input wire [7:0] OBSERVE_SIGNAL_SELECT,
  input wire [1:0] OUTPUT_TYPE_FIELD,
  input wire OUTPUT_DRIVE_ENABLE,
  input wire IO_SUPPLY_OVERVOLTAGE,
  input wire [15:0] MON_SIGNALS,
  input wire [15:0] CLK_SIGNALS,
  input wire [15:0] ILIM_SIGNALS,
  output wire [2:0] ANALOG_CHANNEL,
  output wire ANALOG_DRIVE_EN,
  output wire OBSERVE_PIN_O,
  output wire OBSERVE_PIN_OE
);
  ////////////////////////////////////////////////////////////////////////
  // control registers; host writes are taken as levels each cycle
  wire [7:0] sel_d;
  wire [1:0] type_d;
  wire en_d;
  reg [7:0] sel_q;
  reg [1:0] type_q;
  reg en_q;
  assign sel_d = OBSERVE_SIGNAL_SELECT;
  assign type_d = OUTPUT_TYPE_FIELD;
  assign en_d = OUTPUT_DRIVE_ENABLE;
  // a local copy gives every output the same one-cycle view of a change
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sel_q <= `DOS_SEL_RESET;
      type_q <= `DOS_TYPE_RESET;
      en_q <= `DOS_EN_RESET;
    end else begin
      sel_q <= sel_d;
      type_q <= type_d;
      en_q <= en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // every observed source lives outside this clock: the comparators are
  // analog and the clock taps run from their own oscillators, so each bit
  // passes two flip-flops before the mux reads it
  wire ov_sync;
  wire [15:0] mon_sync;
  wire [15:0] clk_sync;
  wire [15:0] ilim_sync;
  dos_sync2 #(
    .WIDTH(1)
  ) dos_sync2_ov_inst (
    .clk(CORE_CLK),
    .rst(RST),
    .async_in(IO_SUPPLY_OVERVOLTAGE),
    .sync_out(ov_sync)
  );
  dos_sync2 #(
    .WIDTH(16)
  ) dos_sync2_mon_inst (
    .clk(CORE_CLK),
    .rst(RST),
    .async_in(MON_SIGNALS),
    .sync_out(mon_sync)
  );
  dos_sync2 #(
    .WIDTH(16)
  ) dos_sync2_clk_inst (
    .clk(CORE_CLK),
    .rst(RST),
    .async_in(CLK_SIGNALS),
    .sync_out(clk_sync)
  );
  dos_sync2 #(
    .WIDTH(16)
  ) dos_sync2_ilim_inst (
    .clk(CORE_CLK),
    .rst(RST),
    .async_in(ILIM_SIGNALS),
    .sync_out(ilim_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // channel tables; unlisted channel bits are masked to 0 so reserved
  // entries cannot leak whatever the source bus carries
  wire [2:0] grp;
  wire [3:0] ch;
  wire mon_bit;
  wire clk_bit;
  wire ilim_bit;
  assign grp = sel_q[`DOS_GRP_MSB:`DOS_GRP_LSB];
  assign ch = sel_q[`DOS_CH_MSB:`DOS_CH_LSB];
  dos_group_pick #(
    .MASK(`DOS_MON_MASK)
  ) dos_group_pick_mon_inst (
    .sources(mon_sync),
    .channel(ch),
    .picked(mon_bit)
  );
  dos_group_pick #(
    .MASK(`DOS_CLK_MASK)
  ) dos_group_pick_clk_inst (
    .sources(clk_sync),
    .channel(ch),
    .picked(clk_bit)
  );
  dos_group_pick #(
    .MASK(`DOS_ILIM_MASK)
  ) dos_group_pick_ilim_inst (
    .sources(ilim_sync),
    .channel(ch),
    .picked(ilim_bit)
  );

  // bit 7 is ignored in digital mode; groups 011b and up are all reserved
  reg dig_d;
  always @* begin
    dig_d = 1'h0;
    if (grp == `DOS_GRP_MON) begin
      dig_d = mon_bit;
    end else if (grp == `DOS_GRP_CLK) begin
      dig_d = clk_bit;
    end else if (grp == `DOS_GRP_ILIM) begin
      dig_d = ilim_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // drive qualification
  wire a_valid;
  wire live;
  wire a_mode;
  wire d_mode;
  assign a_valid = (sel_q >= `DOS_ACH_FIRST) &&
    (sel_q <= `DOS_ACH_LAST);
  // the overvoltage trip removes supply from both buffers, so it gates
  // analog and digital drive alike; types 00b and 11b drive nothing
  assign live = en_q & ~ov_sync;
  assign a_mode = (type_q == `DOS_TYPE_ANALOG);
  assign d_mode = (type_q == `DOS_TYPE_DIGITAL);

  // next values of the registered outputs; the two buffers are never
  // enabled together because the two type codes exclude each other
  wire dig_out_d;
  wire doe_d;
  wire aen_d;
  wire [2:0] ach_d;
  assign dig_out_d = dig_d & live & d_mode;
  assign doe_d = live & d_mode;
  assign aen_d = live & a_mode & a_valid;
  assign ach_d = aen_d ? sel_q[2:0] : 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // outputs registered; one cycle latency bounds any selection glitch
  reg dig_q;
  reg doe_q;
  reg aen_q;
  reg [2:0] ach_q;
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      dig_q <= `DOS_OUT_RESET;
      doe_q <= `DOS_OUT_RESET;
      aen_q <= `DOS_OUT_RESET;
      ach_q <= `DOS_ACH_RESET;
    end else begin
      dig_q <= dig_out_d;
      doe_q <= doe_d;
      aen_q <= aen_d;
      ach_q <= ach_d;
    end
  end
  assign OBSERVE_PIN_O = dig_q;
  assign OBSERVE_PIN_OE = doe_q;
  assign ANALOG_DRIVE_EN = aen_q;
  assign ANALOG_CHANNEL = ach_q;
endmodule // dos_observe_mux

////////////////////////////////////////////////////////////////////////////
// two-stage synchroniser for levels from another clock or a comparator;
// a bus is safe here only because each bit is observed on its own
module dos_sync2 #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= {WIDTH{`DOS_SYNC_RESET}};
      sync_q <= {WIDTH{`DOS_SYNC_RESET}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  // only the second stage leaves this module
  assign sync_out = sync_q;
endmodule // dos_sync2

////////////////////////////////////////////////////////////////////////////
// one channel group: picks a source bit and forces reserved entries low
module dos_group_pick #(
  parameter [15:0] MASK = 16'hFFFF
) (
  input wire [15:0] sources,
  input wire [3:0] channel,
  output wire picked
);
  wire [15:0] mask_w;
  // a floating or stray source on a reserved channel still reads as 0
  assign mask_w = MASK;
  assign picked = sources[channel] & mask_w[channel];
endmodule // dos_group_pick

// ==== verification/dos_chk_asserts.sv ====
// port assertions for the observe selector
`timescale 1ns/100ps
module dos_chk (
  input wire CORE_CLK,
  input wire RST,
  input wire OUTPUT_DRIVE_ENABLE,
  input wire IO_SUPPLY_OVERVOLTAGE,
  input wire ANALOG_DRIVE_EN,
  input wire OBSERVE_PIN_O,
  input wire OBSERVE_PIN_OE,
  input wire [7:0] OBSERVE_SIGNAL_SELECT,
  input wire [1:0] OUTPUT_TYPE_FIELD,
  input wire [15:0] CLK_SIGNALS,
  input wire [2:0] ANALOG_CHANNEL
);
  wire [7:0] s = OBSERVE_SIGNAL_SELECT;
  wire [1:0] t = OUTPUT_TYPE_FIELD;
  wire ae = ANALOG_DRIVE_EN, oe = OBSERVE_PIN_OE, o = OBSERVE_PIN_O;
  wire g = OUTPUT_DRIVE_ENABLE && !IO_SUPPLY_OVERVOLTAGE;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  property p_off; !OUTPUT_DRIVE_ENABLE |-> ##2 !oe && !ae; endproperty
  a_off: assert property (p_off) else $error("driven");
  property p_an; t == 2'h2 |-> ##2 !oe; endproperty
  a_an: assert property (p_an) else $error("oe");
  property p_dg; t == 2'h1 |-> ##2 !ae && ANALOG_CHANNEL == 3'h0; endproperty
  a_dg: assert property (p_dg) else $error("ae");
  property p_ov; IO_SUPPLY_OVERVOLTAGE |-> ##3 !oe && !ae; endproperty
  a_ov: assert property (p_ov) else $error("ov");
  property p_ach; g[*3] ##0 (t == 2'h2 && s inside {[1:6]}) |->
    ##2 ae && ANALOG_CHANNEL == $past(s[2:0], 2); endproperty
  a_ach: assert property (p_ach) else $error("code");
  property p_ano; t == 2'h2 && !(s inside {[1:6]}) |-> ##2 !ae; endproperty
  a_ano: assert property (p_ano) else $error("ae");
  property p_rsv; t == 2'h1 && s[6:4] > 3'h2 |-> ##2 !o; endproperty
  a_rsv: assert property (p_rsv) else $error("o");
  property p_sck; g[*3] ##0 (t == 2'h1 && s[6:0] == 7'h11) |->
    ##2 oe && o == $past(CLK_SIGNALS[1], 3); endproperty
  a_sck: assert property (p_sck) else $error("clk");
  cover property (ae);
  cover property (oe && o);
  cover property (IO_SUPPLY_OVERVOLTAGE);
endmodule // dos_chk

// ==== verification/dos_mcu.sv ====
// mcu side sampling the observe pin
`timescale 1ns/100ps
module dos_mcu (
  input wire clk,
  input wire o,
  input wire oe,
  output logic pin = 1'h0
);
  // undriven pin wanders so a stale level is never trusted
  always @(posedge clk) pin <= oe ? o : ~pin;
endmodule // dos_mcu

// ==== verification/dos_observe_mux_tb.sv ====
// self-checking bench for the observe selector
`timescale 1ns/100ps
module dos_observe_mux_tb;
  reg CORE_CLK = 0, RST = 1, OUTPUT_DRIVE_ENABLE = 0;
  reg IO_SUPPLY_OVERVOLTAGE = 0, a, d;
  reg [7:0] OBSERVE_SIGNAL_SELECT = 0;
  reg [1:0] OUTPUT_TYPE_FIELD = 0;
  reg [15:0] MON_SIGNALS = 0, CLK_SIGNALS = 0, ILIM_SIGNALS = 0, v;
  wire [2:0] ANALOG_CHANNEL;
  wire ANALOG_DRIVE_EN, OBSERVE_PIN_O, OBSERVE_PIN_OE, pin;
  wire [5:0] seen = {ANALOG_DRIVE_EN, ANALOG_CHANNEL, OBSERVE_PIN_OE,
    OBSERVE_PIN_O};
  integer failures = 0, tests_run = 0, seed = 13, n, r;
  dos_observe_mux dos_observe_mux_inst (
    .CORE_CLK(CORE_CLK),
    .RST(RST),
    .OBSERVE_SIGNAL_SELECT(OBSERVE_SIGNAL_SELECT),
    .OUTPUT_TYPE_FIELD(OUTPUT_TYPE_FIELD),
    .OUTPUT_DRIVE_ENABLE(OUTPUT_DRIVE_ENABLE),
    .IO_SUPPLY_OVERVOLTAGE(IO_SUPPLY_OVERVOLTAGE),
    .MON_SIGNALS(MON_SIGNALS),
    .CLK_SIGNALS(CLK_SIGNALS),
    .ILIM_SIGNALS(ILIM_SIGNALS),
    .ANALOG_CHANNEL(ANALOG_CHANNEL),
    .ANALOG_DRIVE_EN(ANALOG_DRIVE_EN),
    .OBSERVE_PIN_O(OBSERVE_PIN_O),
    .OBSERVE_PIN_OE(OBSERVE_PIN_OE)
  );
  dos_mcu dos_mcu_inst (.clk(CORE_CLK), .o(OBSERVE_PIN_O),
    .oe(OBSERVE_PIN_OE), .pin(pin));
  task conclude;
    begin
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task check(input [5:0] e);
    begin
      tests_run = tests_run + 1;
      if (seen !== e) begin
        failures = failures + 1;
        $display("BAD outputs exp %h got %h", e, seen);
      end
    end
  endtask
  task check_pin(input e);
    begin
      tests_run = tests_run + 1;
      if (pin !== e) begin
        failures = failures + 1;
        $display("BAD pin exp %h got %h", e, pin);
      end
    end
  endtask
  initial forever #10 CORE_CLK = ~CORE_CLK;
  initial begin
    #100000 failures = failures + 1;
    conclude;
  end
  initial begin
    repeat (20) @(negedge CORE_CLK);
    check(6'h00);
    RST = 0;
    for (n = 0; n < 600; n = n + 1) begin
      r = $random(seed);
      OUTPUT_TYPE_FIELD = r[1:0];
      OUTPUT_DRIVE_ENABLE = r[3:2] != 0;
      IO_SUPPLY_OVERVOLTAGE = r[8:4] == 0;
      // bias toward the short analog codes and the clock group
      OBSERVE_SIGNAL_SELECT = r[9] ? {3'h0, r[14], 1'h0, r[12:10]} : r[20:13];
      {MON_SIGNALS, CLK_SIGNALS} = $random(seed);
      r = $random(seed);
      ILIM_SIGNALS = r[15:0];
      repeat (4) @(negedge CORE_CLK);
      r = OBSERVE_SIGNAL_SELECT;
      a = OUTPUT_DRIVE_ENABLE && !IO_SUPPLY_OVERVOLTAGE;
      d = a && OUTPUT_TYPE_FIELD == 2'h1;
      a = a && OUTPUT_TYPE_FIELD == 2'h2 && r > 0 && r < 7;
      v = r[6:4] == 0 ? MON_SIGNALS & 16'h9F82 : r[6:4] == 1 ?
        CLK_SIGNALS & 16'h00BF : r[6:4] == 2 ? ILIM_SIGNALS & 16'h01FE :
        16'h0000;
      check({a, a ? r[2:0] : 3'h0, d, d & v[r[3:0]]});
      if (d) check_pin(v[r[3:0]]);
      // a reset in mid-run must clear every output at once
      if (n == 300) begin
        RST = 1;
        @(negedge CORE_CLK);
        check(6'h00);
        RST = 0;
      end
    end
    conclude;
  end
endmodule // dos_observe_mux_tb
bind dos_observe_mux dos_chk dos_chk_inst (
  .CORE_CLK(CORE_CLK),
  .RST(RST),
  .OUTPUT_DRIVE_ENABLE(OUTPUT_DRIVE_ENABLE),
  .IO_SUPPLY_OVERVOLTAGE(IO_SUPPLY_OVERVOLTAGE),
  .ANALOG_DRIVE_EN(ANALOG_DRIVE_EN),
  .OBSERVE_PIN_O(OBSERVE_PIN_O),
  .OBSERVE_PIN_OE(OBSERVE_PIN_OE),
  .OBSERVE_SIGNAL_SELECT(OBSERVE_SIGNAL_SELECT),
  .OUTPUT_TYPE_FIELD(OUTPUT_TYPE_FIELD),
  .CLK_SIGNALS(CLK_SIGNALS),
  .ANALOG_CHANNEL(ANALOG_CHANNEL)
);
